// ---- src/rbmr_rx_bitcheck.v ----
// Behaviour
// RULE_01 - bit count 0/3/6/9 gives 0..18 checks
// RULE_02 - each verified bit is two interval checks
// RULE_03 - in-window continues, out-of-window aborts to sleep; code goes to start-up instead in mode 11
// RULE_04 - lower limit low*tick, upper (high-1)*tick
// RULE_05 - six-bit low and high limit fields
// RULE_06 - software keeps low >= 10, high <= 63
// RULE_07 - counter advances per tick, compared at edges
// RULE_08 - fail below low at edge, or reaching high
// RULE_09 - advised window 38 or 50 percent, six bits
// RULE_10 - pass enters receive, sets supply and clock enables
// RULE_11 - receive entry interrupts when transparent, pattern zero; code interrupts only when not transparent
// RULE_12 - transparent with chip select low drives stream out
// RULE_13 - non-transparent Manchester data goes to buffer
// RULE_14 - intervals classed T or 2T, T uses limits
// RULE_15 - 2T bounds from sum and half difference, round up
// RULE_16 - bytes stored after start bit, start bit included
// RULE_17 - transmitter start bit opposes preburst value
// RULE_18 - sixteen-byte buffer, overflow overwrites oldest
// RULE_19 - byte counter up on receive, down on read
// RULE_20 - interrupt when counting up reaches threshold
// RULE_21 - bit error interrupts, restarts, drops its byte
// RULE_22 - config write in receive resets buffer, restarts
// RULE_23 - serial output high impedance when not transparent
// RULE_24 - mode 10 polls, mode 11 stays enabled
// RULE_25 - demod ignored until bit check starts counting
`include "rbmr_regs.vh"
module rbmr_rx_bitcheck #(
   parameter LIM_W = `RBMR_LIM_W,
   parameter CNT_W = `RBMR_CNT_W,
   parameter BUF_AW = `RBMR_BUF_AW
) (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // configuration
   input wire op_mode_bit0,
   input wire op_mode_bit1,
   input wire transparent_sel,
   input wire pattern_sel,
   input wire irq_threshold_sel0,
   input wire irq_threshold_sel1,
   input wire [1:0] bitcheck_count,
   input wire [LIM_W-1:0] lim_min,
   input wire [LIM_W-1:0] lim_max,
   input wire ctrl_reg_wr,
   // sequencing and timing
   input wire sleep_done,
   input wire startup_done,
   input wire check_tick,
   input wire demod_out,
   // host side
   input wire cs_n,
   input wire host_rd,
   input wire irq_clear,
   output wire [7:0] rd_data,
   output reg rd_valid_ff,
   output reg [4:0] byte_count_ff,
   output reg irq_ff,
   output reg host_supply_enable_ff,
   output reg host_clock_enable_ff,
   output reg [1:0] state_ff,
   output reg serial_out_rx_stream_ff,
   output reg serial_out_oe_n_ff
);

   ////////////////////////////////////////////////////////////////////////
   // interval windows
   wire [CNT_W-1:0] lmin;
   wire [CNT_W-1:0] lmax;
   wire [CNT_W-1:0] lsum;
   wire [CNT_W-1:0] ldiff;
   wire [CNT_W-1:0] double_window_low;
   wire [CNT_W-1:0] double_window_high;
   wire [4:0] need_checks;
   wire [1:0] op_mode;

   assign lmin = {{(CNT_W-LIM_W){1'b0}}, lim_min}; // RULE_05
   assign lmax = {{(CNT_W-LIM_W){1'b0}}, lim_max}; // RULE_05
   assign lsum = lmin + lmax;
   // assumes high >= low, as software must configure
   assign ldiff = lmax - lmin;
   assign double_window_low = lsum - (ldiff >> 1); // RULE_15
   assign double_window_high = lsum + ((ldiff + 8'h01) >> 1); // RULE_15
   // bits times two checks per bit
   assign need_checks = (`RBMR_BITS_PER_STEP * {3'h0, bitcheck_count})
                        * `RBMR_CHECKS_PER_BIT; // RULE_01 RULE_02
   assign op_mode = {op_mode_bit1, op_mode_bit0};

   reg [CNT_W-1:0] edge_interval_count_ff;
   reg demod_q_ff;
   wire edge_det;
   wire in_t;
   wire in_2t;

   assign edge_det = demod_out ^ demod_q_ff;
   // at an edge: upper bound is (high-1) ticks, so count < high passes
   assign in_t = (edge_interval_count_ff >= lmin) &&
                 (edge_interval_count_ff < lmax); // RULE_04 RULE_14
   assign in_2t = (edge_interval_count_ff >= double_window_low) &&
                  (edge_interval_count_ff < double_window_high); // RULE_14

   ////////////////////////////////////////////////////////////////////////
   // sequencer, bit check and decoder
   reg [4:0] checks_ff;
   reg armed_ff;
   reg started_ff;
   reg mid_ff;
   reg [7:0] shift_ff;
   reg [2:0] nbit_ff;
   reg pend_ff;
   reg [7:0] pend_data_ff;
   reg ev_irq_ff;
   wire push;
   wire clear_buf;

   assign clear_buf = ctrl_reg_wr && (state_ff == `RBMR_ST_RECEIVE);

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         demod_q_ff <= 1'b0;
      end else begin
         demod_q_ff <= demod_out;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= `RBMR_ST_SLEEP;
         edge_interval_count_ff <= 8'h00;
         checks_ff <= 5'h00;
         armed_ff <= 1'b0;
         started_ff <= 1'b0;
         mid_ff <= 1'b0;
         shift_ff <= 8'h00;
         nbit_ff <= 3'h0;
         pend_ff <= 1'b0;
         pend_data_ff <= 8'h00;
         ev_irq_ff <= 1'b0;
         host_supply_enable_ff <= 1'b0;
         host_clock_enable_ff <= 1'b0;
      end else begin
         ev_irq_ff <= 1'b0;
         if (push) begin
            pend_ff <= 1'b0;
         end
         // ticks only counted in check and receive, saturating
         if (check_tick && (state_ff[1]) &&
             (edge_interval_count_ff != 8'hff)) begin
            edge_interval_count_ff <= edge_interval_count_ff + 8'h01; // RULE_07
         end
         if (!op_mode_bit1) begin
            state_ff <= `RBMR_ST_SLEEP; // RULE_24
         end else begin
            case (state_ff)
               `RBMR_ST_SLEEP: begin
                  if (op_mode == `RBMR_OPM_RX || sleep_done) begin
                     state_ff <= `RBMR_ST_STARTUP; // RULE_24
                  end
               end
               `RBMR_ST_STARTUP: begin
                  // demod is undefined here and is not looked at
                  if (startup_done) begin
                     state_ff <= `RBMR_ST_BITCHECK; // RULE_25
                     edge_interval_count_ff <= 8'h00;
                     checks_ff <= 5'h00;
                     armed_ff <= 1'b0;
                  end
               end
               `RBMR_ST_BITCHECK: begin
                  if (need_checks == 5'h00) begin
                     state_ff <= `RBMR_ST_RECEIVE; // RULE_01
                  end else if (edge_det) begin
                     edge_interval_count_ff <= 8'h00; // RULE_07
                     armed_ff <= 1'b1;
                     // first edge only opens the first interval
                     if (armed_ff && !in_t) begin
                        state_ff <= (op_mode == `RBMR_OPM_RX) ?
                           `RBMR_ST_STARTUP : `RBMR_ST_SLEEP; // RULE_03
                     end else if (armed_ff) begin
                        checks_ff <= checks_ff + 5'h01; // RULE_02
                        if (checks_ff + 5'h01 == need_checks) begin
                           state_ff <= `RBMR_ST_RECEIVE; // RULE_01
                        end
                     end
                  end else if (edge_interval_count_ff >= lmax) begin
                     state_ff <= (op_mode == `RBMR_OPM_RX) ?
                        `RBMR_ST_STARTUP : `RBMR_ST_SLEEP; // RULE_08
                  end
                  if (state_ff == `RBMR_ST_BITCHECK) begin
                     started_ff <= 1'b0;
                     mid_ff <= 1'b0;
                     nbit_ff <= 3'h0;
                  end
               end
               `RBMR_ST_RECEIVE: begin
                  if (clear_buf) begin
                     started_ff <= 1'b0;
                     nbit_ff <= 3'h0;
                     pend_ff <= 1'b0; // RULE_22
                     state_ff <= (op_mode == `RBMR_OPM_RX) ?
                        `RBMR_ST_STARTUP : `RBMR_ST_SLEEP; // RULE_22
                  end else if (!transparent_sel) begin // RULE_13
                     if (edge_det) begin
                        edge_interval_count_ff <= 8'h00;
                        if (!in_t && !in_2t) begin
                           ev_irq_ff <= 1'b1; // RULE_21
                           state_ff <= `RBMR_ST_STARTUP; // RULE_21
                        end else if (!started_ff) begin
                           // preburst gives T; first 2T is the start bit
                           if (in_2t) begin
                              started_ff <= 1'b1; // RULE_16
                              mid_ff <= 1'b1;
                              shift_ff <= {shift_ff[6:0], demod_out}; // RULE_16
                              nbit_ff <= 3'h1;
                           end
                        end else if (mid_ff && in_t) begin
                           mid_ff <= 1'b0;
                        end else if (!mid_ff && !in_t) begin
                           // no edge at bit centre
                           ev_irq_ff <= 1'b1; // RULE_21
                           state_ff <= `RBMR_ST_STARTUP; // RULE_21
                        end else begin
                           mid_ff <= 1'b1;
                           shift_ff <= {shift_ff[6:0], demod_out};
                           nbit_ff <= nbit_ff + 3'h1;
                           if (nbit_ff == `RBMR_BYTE_LAST) begin
                              // one byte of slack; if still pending it
                              // is replaced, far slower than a drain
                              pend_ff <= 1'b1; // RULE_16
                              pend_data_ff <= {shift_ff[6:0], demod_out};
                           end
                        end
                     end else if (edge_interval_count_ff >=
                                  double_window_high) begin
                        // partial byte dropped, never stored
                        ev_irq_ff <= 1'b1; // RULE_21
                        state_ff <= `RBMR_ST_STARTUP; // RULE_21
                     end
                  end
               end
               default: begin
                  state_ff <= `RBMR_ST_SLEEP;
               end
            endcase
         end
         if (state_ff == `RBMR_ST_BITCHECK && need_checks == 5'h00) begin
            host_supply_enable_ff <= 1'b1; // RULE_10
            host_clock_enable_ff <= 1'b1; // RULE_10
            ev_irq_ff <= !transparent_sel && !pattern_sel; // RULE_11
         end else if (state_ff == `RBMR_ST_BITCHECK && edge_det &&
                      armed_ff && in_t &&
                      checks_ff + 5'h01 == need_checks) begin
            host_supply_enable_ff <= 1'b1; // RULE_10
            host_clock_enable_ff <= 1'b1; // RULE_10
            ev_irq_ff <= !transparent_sel && !pattern_sel; // RULE_11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transparent output
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         serial_out_rx_stream_ff <= 1'b0;
         serial_out_oe_n_ff <= 1'b1;
      end else begin
         serial_out_rx_stream_ff <= demod_out; // RULE_12
         // released unless transparent receive with chip select low
         serial_out_oe_n_ff <= !(transparent_sel && !cs_n &&
                                 state_ff == `RBMR_ST_RECEIVE); // RULE_12 RULE_23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry buffer between decoder and ring
   reg [7:0] f_d0_ff;
   reg [7:0] f_d1_ff;
   reg [1:0] f_cnt_ff;
   reg [BUF_AW-1:0] wr_ptr_ff;
   reg [BUF_AW-1:0] rd_ptr_ff;
   wire rd_take;
   wire pop;
   reg [4:0] thr;

   // host reads take priority over pops; pops stall meanwhile
   assign rd_take = host_rd && (byte_count_ff != 5'h00);
   assign pop = (f_cnt_ff != 2'h0) && !rd_take;
   assign push = pend_ff && (f_cnt_ff != 2'h2);

   always @* begin
      case ({irq_threshold_sel1, irq_threshold_sel0})
         2'h0: thr = `RBMR_THR_SEL0;
         2'h1: thr = `RBMR_THR_SEL1;
         2'h2: thr = `RBMR_THR_SEL2;
         default: thr = `RBMR_THR_SEL3;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         f_d0_ff <= 8'h00;
         f_d1_ff <= 8'h00;
         f_cnt_ff <= 2'h0;
      end else if (clear_buf) begin
         f_cnt_ff <= 2'h0; // RULE_22
      end else begin
         if (pop && push && f_cnt_ff == 2'h1) begin
            f_d0_ff <= pend_data_ff;
         end else if (pop) begin
            f_d0_ff <= f_d1_ff;
            if (push) begin
               f_d1_ff <= pend_data_ff;
            end
         end else if (push && f_cnt_ff == 2'h0) begin
            f_d0_ff <= pend_data_ff;
         end else if (push) begin
            f_d1_ff <= pend_data_ff;
         end
         f_cnt_ff <= f_cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ring, byte counter, interrupt
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_ff <= 4'h0;
         rd_ptr_ff <= 4'h0;
         byte_count_ff <= 5'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= rd_take;
         if (clear_buf) begin
            wr_ptr_ff <= 4'h0; // RULE_22
            rd_ptr_ff <= 4'h0;
            byte_count_ff <= 5'h00; // RULE_22
         end else if (rd_take) begin
            rd_ptr_ff <= rd_ptr_ff + 4'h1;
            byte_count_ff <= byte_count_ff - 5'h01; // RULE_19
         end else if (pop) begin
            wr_ptr_ff <= wr_ptr_ff + 4'h1;
            if (byte_count_ff == `RBMR_BUF_FULL) begin
               // overflow: oldest byte is overwritten
               rd_ptr_ff <= rd_ptr_ff + 4'h1; // RULE_18
            end else begin
               byte_count_ff <= byte_count_ff + 5'h01; // RULE_19
            end
         end
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else if (ev_irq_ff || (pop && !clear_buf &&
               byte_count_ff != `RBMR_BUF_FULL &&
               byte_count_ff + 5'h01 == thr)) begin
         // set wins over a clear in the same cycle
         irq_ff <= 1'b1; // RULE_20 RULE_21
      end else if (irq_clear) begin
         irq_ff <= 1'b0;
      end
   end

   rbmr_mem #(
      .DW(8),
      .DEPTH(`RBMR_BUF_DEPTH),
      .AW(BUF_AW)
   ) u_mem (
      .sys_clk(sys_clk),
      .we(pop && !clear_buf),
      .waddr(wr_ptr_ff),
      .wdata(f_d0_ff),
      .re(rd_take),
      .raddr(rd_ptr_ff),
      .rdata_ff(rd_data)
   ); // RULE_18

endmodule

// ---- src/rbmr_regs.vh ----
`ifndef RBMR_REGS_VH
`define RBMR_REGS_VH

////////////////////////////////////////////////////////////////////////////
// receiver states
`define RBMR_ST_SLEEP 2'h0
`define RBMR_ST_STARTUP 2'h1
`define RBMR_ST_BITCHECK 2'h2
`define RBMR_ST_RECEIVE 2'h3

////////////////////////////////////////////////////////////////////////////
// operating mode field (bit1, bit0)
`define RBMR_OPM_POLL 2'h2
`define RBMR_OPM_RX 2'h3

////////////////////////////////////////////////////////////////////////////
// bit check: edge checks per verified bit, field widths
`define RBMR_CHECKS_PER_BIT 5'h02
`define RBMR_BITS_PER_STEP 5'h03
`define RBMR_LIM_W 6
`define RBMR_CNT_W 8

////////////////////////////////////////////////////////////////////////////
// byte counter interrupt thresholds, selected by the two threshold bits
`define RBMR_THR_SEL0 5'h01
`define RBMR_THR_SEL1 5'h04
`define RBMR_THR_SEL2 5'h08
`define RBMR_THR_SEL3 5'h0c

////////////////////////////////////////////////////////////////////////////
// receive buffer
`define RBMR_BUF_DEPTH 16
`define RBMR_BUF_AW 4
`define RBMR_BUF_FULL 5'h10
`define RBMR_BYTE_LAST 3'h7

`endif

// ---- src/rbmr_mem.v ----
`include "rbmr_regs.vh"
module rbmr_mem #(
   parameter DW = 8,
   parameter DEPTH = `RBMR_BUF_DEPTH,
   parameter AW = `RBMR_BUF_AW
) (
   // clock
   input wire sys_clk,
   // write side
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // read side
   input wire re,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata_ff
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // storage has no reset; read data is not initialised either
   always @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge sys_clk) begin
      if (re) begin
         rdata_ff <= mem[raddr];
      end
   end

endmodule

// ---- verif/rbmr_rx_bitcheck_asserts.sv ----
module rbmr_rx_bitcheck_asserts (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // configuration
   input wire op_mode_bit0,
   input wire op_mode_bit1,
   input wire transparent_sel,
   input wire pattern_sel,
   input wire irq_threshold_sel0,
   input wire irq_threshold_sel1,
   input wire ctrl_reg_wr,
   // sequencing and data
   input wire sleep_done,
   input wire startup_done,
   input wire demod_out,
   // host side
   input wire cs_n,
   input wire host_rd,
   input wire rd_valid_ff,
   input wire [4:0] byte_count_ff,
   input wire irq_ff,
   input wire host_supply_enable_ff,
   input wire host_clock_enable_ff,
   input wire [1:0] state_ff,
   input wire serial_out_rx_stream_ff,
   input wire serial_out_oe_n_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   wire [4:0] thr;
   wire rx_out;
   assign thr = irq_threshold_sel1 ? (irq_threshold_sel0 ? 5'h0c : 5'h08)
      : (irq_threshold_sel0 ? 5'h04 : 5'h01);
   assign rx_out = state_ff == 2'h3 && transparent_sel && !cs_n;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   AST_WAKE_RX: assert property (
      state_ff == 2'h0 && op_mode_bit1 && op_mode_bit0 |=> state_ff == 2'h1)
      else $error("rx mode did not leave sleep");
   AST_POLL_SLEEP: assert property (
      state_ff == 2'h0 && op_mode_bit1 && !op_mode_bit0
      |=> state_ff == {1'b0, $past(sleep_done)})
      else $error("polling sleep exit wrong");
   AST_MODE_OFF: assert property (
      !op_mode_bit1 |=> state_ff == 2'h0)
      else $error("receiver off but not asleep");
   AST_STARTUP: assert property (
      state_ff == 2'h1 && op_mode_bit1
      |=> state_ff == ($past(startup_done) ? 2'h2 : 2'h1))
      else $error("start-up exit wrong");
   AST_ENABLES: assert property (
      state_ff == 2'h3 || host_supply_enable_ff
      |=> host_supply_enable_ff && host_clock_enable_ff)
      else $error("host enables not set");
   AST_ENTRY_IRQ: assert property (
      state_ff == 2'h2 ##1 (state_ff == 2'h3 && !transparent_sel
      && !pattern_sel) |=> irq_ff)
      else $error("no interrupt on receive entry");
   AST_PIN_OFF: assert property (
      !rx_out ##1 !rx_out |-> serial_out_oe_n_ff)
      else $error("serial pin driven while not transparent");
   AST_PIN_ON: assert property (
      rx_out ##1 rx_out |-> !serial_out_oe_n_ff
      && serial_out_rx_stream_ff == $past(demod_out))
      else $error("stream not on serial pin");
   AST_READ_VALID: assert property (
      rd_valid_ff == ($past(host_rd) && $past(byte_count_ff) != 5'h00))
      else $error("read valid pulse wrong");
   AST_READ_COUNT: assert property (
      host_rd && byte_count_ff != 5'h00 && !ctrl_reg_wr
      |=> byte_count_ff + 5'h01 == $past(byte_count_ff))
      else $error("count not lowered by read");
   AST_COUNT_MAX: assert property (
      byte_count_ff <= 5'h10)
      else $error("byte count above buffer size");
   AST_THRESHOLD: assert property (
      byte_count_ff == thr && $past(byte_count_ff) + 5'h01 == thr
      |-> ##[0:2] irq_ff)
      else $error("no interrupt at byte threshold");
   AST_CFG_WRITE: assert property (
      state_ff == 2'h3 && ctrl_reg_wr |=> byte_count_ff == 5'h00
      && state_ff == {1'b0, $past(op_mode_bit1 && op_mode_bit0)})
      else $error("config write in receive not handled");
endmodule

// ---- verif/rbmr_host_model.sv ----
module rbmr_host_model (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // bench control: low stalls the host
   input wire rd_en,
   // receiver host side
   input wire [4:0] byte_count_ff,
   input wire rd_valid_ff,
   input wire [7:0] rd_data,
   output logic host_rd
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] got[$];
   // every other cycle only, so a stale count never causes a dead read
   initial begin
      host_rd = 1'b0;
      forever begin
         @(posedge sys_clk);
         #1;
         if (rd_valid_ff) got.push_back(rd_data);
         host_rd = rd_en && nrst && byte_count_ff != 5'h00 && !host_rd;
      end
   end
endmodule

// ---- verif/tb_rbmr_rx_bitcheck.sv ----
module tb_rbmr_rx_bitcheck;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, nrst, op_mode_bit0, op_mode_bit1, transparent_sel;
   logic pattern_sel, irq_threshold_sel0, irq_threshold_sel1, ctrl_reg_wr;
   logic sleep_done, startup_done, check_tick, demod_out, cs_n, host_rd;
   logic irq_clear, rd_en, rd_valid_ff, irq_ff, host_supply_enable_ff;
   logic host_clock_enable_ff, serial_out_rx_stream_ff, serial_out_oe_n_ff;
   logic [1:0] bitcheck_count, state_ff;
   logic [5:0] lim_min, lim_max;
   logic [7:0] rd_data, b;
   logic [4:0] byte_count_ff;
   logic [7:0] sent[$];
   integer seed, n_fail, cmp_count, cyc, i, j, k, n;
   rbmr_rx_bitcheck i_rbmr_rx_bitcheck (.sys_clk(sys_clk), .nrst(nrst),
      .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
      .transparent_sel(transparent_sel), .pattern_sel(pattern_sel),
      .irq_threshold_sel0(irq_threshold_sel0),
      .irq_threshold_sel1(irq_threshold_sel1),
      .bitcheck_count(bitcheck_count), .lim_min(lim_min), .lim_max(lim_max),
      .ctrl_reg_wr(ctrl_reg_wr), .sleep_done(sleep_done),
      .startup_done(startup_done), .check_tick(check_tick),
      .demod_out(demod_out), .cs_n(cs_n), .host_rd(host_rd),
      .irq_clear(irq_clear), .rd_data(rd_data), .rd_valid_ff(rd_valid_ff),
      .byte_count_ff(byte_count_ff), .irq_ff(irq_ff),
      .host_supply_enable_ff(host_supply_enable_ff),
      .host_clock_enable_ff(host_clock_enable_ff), .state_ff(state_ff),
      .serial_out_rx_stream_ff(serial_out_rx_stream_ff),
      .serial_out_oe_n_ff(serial_out_oe_n_ff));
   rbmr_host_model i_rbmr_host_model (.sys_clk(sys_clk), .nrst(nrst),
      .rd_en(rd_en), .byte_count_ff(byte_count_ff), .rd_valid_ff(rd_valid_ff),
      .rd_data(rd_data), .host_rd(host_rd));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // one check tick every two cycles
   always @(posedge sys_clk) check_tick <= #1 ~check_tick;
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tk(input integer nc);
      repeat (nc) @(posedge sys_clk);
      #1;
   endtask
   task half(input logic lv, input integer t);
      demod_out = lv;
      tk(2 * t);
   endtask
   // manchester: value is the level after the centre edge
   task send_bit(input logic v);
      half(~v, 19);
      half(v, 19);
   endtask
   task to_check;
      tk(2);
      startup_done = 1'b1;
      tk(1);
      startup_done = 1'b0;
      chk(8'(state_ff), 8'h02);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h7697e0e7;
      {n_fail, cmp_count, cyc} = 0;
      {op_mode_bit1, op_mode_bit0, transparent_sel, pattern_sel} = 4'hc;
      {irq_threshold_sel0, irq_threshold_sel1, ctrl_reg_wr} = 3'h0;
      {sleep_done, startup_done, check_tick, demod_out} = 4'h0;
      {irq_clear, rd_en, cs_n, bitcheck_count} = 5'h04;
      lim_min = 6'h0e;
      lim_max = 6'h18;
      nrst = 1'b0;
      tk(4);
      nrst = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         bitcheck_count = 2'(i);
         pattern_sel = i[0];
         to_check();
         if (i == 0) tk(1);
         else begin
            repeat (6 * i) half(~demod_out, 16 + ($random(seed) & 3));
            chk(8'(state_ff), 8'h02);
            half(~demod_out, 20);
         end
         chk(8'(state_ff), 8'h03);
         tk(1);
         chk(8'(irq_ff), 8'(!pattern_sel));
         chk(8'({host_supply_enable_ff, host_clock_enable_ff}), 8'h03);
         {irq_clear, ctrl_reg_wr} = 2'h3;
         tk(1);
         {irq_clear, ctrl_reg_wr} = 2'h0;
         tk(1);
         chk(8'(state_ff), 8'h01);
         chk(8'(irq_ff), 8'h00);
      end
      // polling: too short an interval, then no edge at all
      op_mode_bit0 = 1'b0;
      bitcheck_count = 2'h1;
      to_check();
      half(~demod_out, 18);
      half(~demod_out, 8);
      // third edge ends the short interval and is the one judged
      half(~demod_out, 1);
      chk(8'(state_ff), 8'h00);
      tk(20);
      chk(8'(state_ff), 8'h00);
      sleep_done = 1'b1;
      tk(1);
      sleep_done = 1'b0;
      chk(8'(state_ff), 8'h01);
      to_check();
      half(~demod_out, 18);
      tk(60);
      chk(8'(state_ff), 8'h00);
      // buffered: stalled host with overflow, then live host
      {op_mode_bit0, pattern_sel} = 2'h3;
      for (k = 0; k < 2; k = k + 1) begin
         {irq_threshold_sel1, irq_threshold_sel0} = 2'($random(seed));
         rd_en = k[0];
         demod_out = 1'b0;
         sent.delete();
         i_rbmr_host_model.got.delete();
         to_check();
         repeat (8) send_bit(1'b0);
         for (i = 0; i < (k ? 3 : 18); i = i + 1) begin
            b = 8'($random(seed));
            if (i == 0) b[7] = 1'b1;
            sent.push_back(b);
            for (j = 7; j >= 0; j = j - 1) send_bit(b[j]);
         end
         repeat (3) send_bit(1'($random(seed)));
         irq_clear = 1'b1;
         tk(1);
         irq_clear = 1'b0;
         tk(120);
         chk(8'(state_ff), 8'h01);
         chk(8'(irq_ff), 8'h01);
         chk(8'(byte_count_ff), k ? 8'h00 : 8'h10);
         rd_en = 1'b1;
         repeat (100) if (byte_count_ff != 5'h00) tk(1);
         tk(4);
         n = k ? 0 : 2;
         chk(8'(i_rbmr_host_model.got.size()), 8'(sent.size() - n));
         for (i = 0; i < i_rbmr_host_model.got.size(); i = i + 1)
            chk(i_rbmr_host_model.got[i], sent[i + n]);
      end
      // transparent stream on the serial pin
      {transparent_sel, cs_n, bitcheck_count, irq_clear} = 5'h11;
      to_check();
      irq_clear = 1'b0;
      chk(8'(serial_out_oe_n_ff), 8'h01);
      tk(2);
      chk(8'(irq_ff), 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         demod_out = 1'($random(seed));
         tk(1);
         chk(8'({serial_out_oe_n_ff, serial_out_rx_stream_ff}),
            8'(demod_out));
      end
      cs_n = 1'b1;
      tk(2);
      chk(8'(serial_out_oe_n_ff), 8'h01);
      // receiver switched off from receive falls straight to sleep
      op_mode_bit1 = 1'b0;
      tk(2);
      chk(8'(state_ff), 8'h00);
      end_sim();
   end
endmodule

bind rbmr_rx_bitcheck rbmr_rx_bitcheck_asserts i_rbmr_rx_bitcheck_asserts (
   .sys_clk(sys_clk), .nrst(nrst), .op_mode_bit0(op_mode_bit0),
   .op_mode_bit1(op_mode_bit1), .transparent_sel(transparent_sel),
   .pattern_sel(pattern_sel), .irq_threshold_sel0(irq_threshold_sel0),
   .irq_threshold_sel1(irq_threshold_sel1), .ctrl_reg_wr(ctrl_reg_wr),
   .sleep_done(sleep_done), .startup_done(startup_done),
   .demod_out(demod_out), .cs_n(cs_n), .host_rd(host_rd),
   .rd_valid_ff(rd_valid_ff), .byte_count_ff(byte_count_ff),
   .irq_ff(irq_ff), .host_supply_enable_ff(host_supply_enable_ff),
   .host_clock_enable_ff(host_clock_enable_ff), .state_ff(state_ff),
   .serial_out_rx_stream_ff(serial_out_rx_stream_ff),
   .serial_out_oe_n_ff(serial_out_oe_n_ff));
